// file: include/cgcsr_pkg.sv
/*
 Constants for the clock generator control and status register bank:
 register addresses, field positions, reset values and the serial port
 state encoding. Assumes 7-bit register addresses and 8-bit registers.
*/
package cgcsr_pkg;
   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int REG_AW = 7;
   localparam int REG_DW = 8;
   localparam int SPI_WORD_BITS = 16;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // ------------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------------
   localparam logic [6:0] ADDR_P_DIV = 7'h00;
   localparam logic [6:0] ADDR_M_DIV_HI = 7'h01;
   localparam logic [6:0] ADDR_M_DIV_LO = 7'h02;
   localparam logic [6:0] ADDR_N0_DIV = 7'h03;
   localparam logic [6:0] ADDR_N1_DIV = 7'h04;
   localparam logic [6:0] ADDR_OUTPUT_INPUT_CONTROL = 7'h05;
   localparam logic [6:0] ADDR_HOLDOVER_MISC_CONTROL = 7'h06;
   localparam logic [6:0] ADDR_INPUT_MONITOR_STATUS = 7'h07;
   localparam logic [6:0] ADDR_RESERVED = 7'h08;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int OIC_OUT_DIS = 7;
   localparam int OIC_EN_FIRST = 6;
   localparam int OIC_EN_SECOND = 5;
   localparam int OIC_DEF_B = 4;
   localparam int OIC_IN_EN_HI = 3;
   localparam int OIC_IN_EN_LO = 2;
   localparam int OIC_REVERT = 1;
   localparam int OIC_MON_RST = 0;
   localparam int HMC_HOLD_EN = 7;
   localparam int HMC_FORCE = 6;
   localparam int HMC_ACQ_NOM = 5;
   localparam int HMC_SW_RST = 4;
   localparam int HMC_DIV_ROUTE = 2;
   localparam int HMC_ACQ_SEL = 1;
   localparam logic [1:0] IN_EN_BY_PINS = 2'h0;

   // ------------------------------------------------------------------
   // Reset values and write masks
   // ------------------------------------------------------------------
   localparam logic [7:0] OIC_RESET = 8'h60;
   localparam logic [7:0] HMC_RESET = 8'h00;
   localparam logic [7:0] ZERO_RESET = 8'h00;
   localparam logic [7:0] OIC_STORE_MASK = 8'hFE;
   localparam logic [7:0] HMC_STORE_MASK = 8'hEE;
   localparam logic [6:0] I2C_DEV_ADDR = 7'h68;

   // ------------------------------------------------------------------
   // Two-wire port states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD = 3'b010,
      ST_WDATA = 3'b011,
      ST_ACK = 3'b100,
      ST_RDATA = 3'b101,
      ST_RACK = 3'b110
   } cgcsr_i2c_st_t;
endpackage

// file: include/cgcsr_wr_if.sv
/*
 Register write request from a serial front end to the register bank.
 Assumes one-cycle write strobes on core_clk.
*/
`timescale 1ns/1ps
interface cgcsr_wr_if;
   logic wrStb;
   logic [6:0] wrAddr;
   logic [7:0] wrData;
   modport src (output wrStb, output wrAddr, output wrData);
   modport dst (input wrStb, input wrAddr, input wrData);
endinterface

// file: rtl/cgcsr_spi_rx.sv
/*
 Write-only three-wire receiver: gathers a 16-bit word MSB first and
 issues one register write when chip select rises after 16 bits with the MSB clear. Assumes pins are
 synchronous to core_clk and SCL is slow against it.
*/
`timescale 1ns/1ps
module cgcsr_spi_rx
   import cgcsr_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic enable, // Three-wire port selected
   input wire logic csN, // Chip select, active low
   input wire logic scl, // Serial clock
   input wire logic sda, // Serial data
   cgcsr_wr_if.src wr // Write request out
);
   typedef struct packed {
      logic sclPrev;
      logic csPrev;
      logic [15:0] shift;
      logic [4:0] cnt;
      logic stb;
      logic [6:0] addr;
      logic [7:0] data;
   } cgcsr_spi_state_t;

   localparam cgcsr_spi_state_t SPI_RST = '{csPrev: 1'b1, default: '0};
   localparam logic [4:0] WORD_CNT = 5'(SPI_WORD_BITS);

   cgcsr_spi_state_t s_reg;
   cgcsr_spi_state_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.sclPrev = scl;
      s_next.csPrev = csN;
      s_next.stb = 1'b0;
      if (enable && !csN && s_reg.csPrev) begin
         s_next.cnt = 5'h00;
      end else if (enable && !csN && scl && !s_reg.sclPrev) begin
         s_next.shift = {s_reg.shift[14:0], sda};
         if (s_reg.cnt != WORD_CNT) begin
            s_next.cnt = s_reg.cnt + 5'h01;
         end
      end else if (enable && csN && !s_reg.csPrev) begin
         if (s_reg.cnt == WORD_CNT && !s_reg.shift[15]) begin
            s_next.stb = 1'b1;
            s_next.addr = s_reg.shift[14:8];
            s_next.data = s_reg.shift[7:0];
         end
         s_next.cnt = 5'h00;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_reg <= SPI_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wr.wrStb = s_reg.stb;
   assign wr.wrAddr = s_reg.addr;
   assign wr.wrData = s_reg.data;
endmodule

// file: rtl/cgcsr_holdover.sv
/*
 Holdover control: captures the nominal crystal control word and picks
 what steers the crystal. Assumes pllCtrl is a word in the core domain.
*/
`timescale 1ns/1ps
module cgcsr_holdover
   import cgcsr_pkg::*;
#(
   parameter int CTRL_W = 16
) (
   input wire logic core_clk, // Core clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic holdEn, // Holdover allowed
   input wire logic forceHold, // Forced holdover
   input wire logic acqNominal, // Acquire nominal command level
   input wire logic acqSel, // Crystal held at captured value
   input wire logic bothFailed, // No usable reference
   input wire logic [CTRL_W-1:0] pllCtrl, // Live PLL control word
   output logic [CTRL_W-1:0] xtalCtrl, // Word steering the crystal
   output logic inHoldover // Holdover state
);
   typedef struct packed {
      logic forcePrev;
      logic acqPrev;
      logic [CTRL_W-1:0] nominal;
      logic [CTRL_W-1:0] xtal;
      logic hold;
   } cgcsr_hold_state_t;

   cgcsr_hold_state_t s_reg;
   cgcsr_hold_state_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.forcePrev = forceHold;
      s_next.acqPrev = acqNominal;
      if ((forceHold && !s_reg.forcePrev) ||
          (acqNominal && !s_reg.acqPrev)) begin
         s_next.nominal = pllCtrl;
      end
      s_next.hold = holdEn && (forceHold || bothFailed);
      if (acqSel || s_reg.hold) begin
         s_next.xtal = s_reg.nominal;
      end else begin
         s_next.xtal = pllCtrl;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign xtalCtrl = s_reg.xtal;
   assign inHoldover = s_reg.hold;
endmodule

// file: rtl/cgcsr_top.sv
/*
 Control and status register bank of a two-reference clock generator
 with input monitor and holdover, reached over a two-wire port or a
 write-only three-wire port. Assumes all pins synchronous to core_clk,
 serial clocks far slower than core_clk, and failure and lock levels
 supplied by the analog monitor.
*/
`timescale 1ns/1ps
// Summary of operation
// - Output-disable bit set forces enabled clock outputs low.
// - First-output enable clear floats the first output, overriding disable.
// - Second-output enable clear floats the second output, overriding disable.
// - Default-input bit picks input A (0) or input B (1).
// - Input-enable field: 00 pins, 01 A only, 10 B only, 11 both.
// - Revert bit set makes the monitor revertive, else nonrevertive.
// - Monitor reset in revert mode clears interrupt, returns to default.
// - Holdover-enable bit allows holdover; clear disables it.
// - Forced-holdover bit forces holdover; its rise captures nominal.
// - Each rise of acquire-nominal captures the present PLL control word.
// - Writing master-reset bit resets the chip like the reset pin.
// - Divider-route bit sends first or second divider to third output.
// - Acquire-select or holdover holds crystal at captured value, else PLL steers.
// - Status shows per-input failure and PLL unlocked as ones.
// - Active-input status reads 0 for input A, 1 for input B.
// - Holdover status reads 1 while in holdover.
// - Control registers reset to 0x60 and 0x00.
// - Divider, status and reserved registers reset to zero.
// - Two-wire multi-byte writes advance the register address by one.
module cgcsr_top
   import cgcsr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = I2C_DEV_ADDR,
   parameter int CTRL_W = 16
) (
   input wire logic core_clk, // Core clock, 200 MHz
   input wire logic resetn, // Synchronous reset, active low
   input wire logic masterResetPin, // Master reset input, active high
   input wire logic spiModeSel, // 1: three-wire port, 0: two-wire
   input wire logic i2cScl, // Two-wire clock
   input wire logic i2cSdaIn, // Two-wire data in
   output logic i2cSdaOut, // Two-wire data out, always low
   output logic i2cSdaOen, // Two-wire data enable, low drives
   input wire logic spiCsN, // Three-wire chip select, active low
   input wire logic spiScl, // Three-wire clock
   input wire logic spiSda, // Three-wire data
   input wire logic inputSelectPinA, // Select pin enabling input A
   input wire logic inputSelectPinB, // Select pin enabling input B
   input wire logic refFailA, // Input A failure level
   input wire logic refFailB, // Input B failure level
   input wire logic pllUnlocked, // PLL not locked
   input wire logic divFirstClk, // First output divider
   input wire logic divSecondClk, // Second output divider
   input wire logic [CTRL_W-1:0] pllCtrl, // Live PLL control word
   output logic clockOutputFirst, // First clock output
   output logic clockOutputFirstOen, // First output enable, low drives
   output logic clockOutputSecond, // Second clock output
   output logic clockOutputSecondOen, // Second output enable, low drives
   output logic clockOutputThird, // Third clock output
   output logic refInputBActive, // 1: PLL fed by input B
   output logic monitorIntr, // Monitor interrupt, active high
   output logic [CTRL_W-1:0] xtalCtrl, // Crystal control word
   output logic [7:0] pDivRatio, // P divider code
   output logic [15:0] mDivRatio, // M divider code
   output logic [7:0] n0DivRatio, // First output divider code
   output logic [7:0] n1DivRatio // Second output divider code
);
   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      cgcsr_i2c_st_t st;
      cgcsr_i2c_st_t afterAck;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic [6:0] ptr;
      logic sclPrev;
      logic sdaPrev;
      logic sdaOen;
      logic [7:0] pDiv;
      logic [7:0] mHi;
      logic [7:0] mLo;
      logic [7:0] n0;
      logic [7:0] n1;
      logic [7:0] oic;
      logic [7:0] hmc;
      logic [7:0] status;
      logic [7:0] rsvd;
      logic monRst;
      logic swRst;
      logic useB;
      logic intFlag;
      logic failAPrev;
      logic failBPrev;
      logic clock_output_second;
      logic clk1Oen;
      logic clock_output_third;
      logic clk2Oen;
      logic clk3;
   } cgcsr_top_state_t;

   localparam cgcsr_top_state_t TOP_RST = '{
      st: ST_IDLE,
      afterAck: ST_IDLE,
      sclPrev: 1'b1,
      sdaPrev: 1'b1,
      sdaOen: 1'b1,
      oic: OIC_RESET,
      hmc: HMC_RESET,
      status: ZERO_RESET,
      default: '0
   };

   cgcsr_top_state_t s_reg;
   cgcsr_top_state_t s_next;
   logic coreRstn;
   logic inHold;
   logic enA;
   logic enB;
   logic bothFailed;

   cgcsr_wr_if spiWr();

   // ------------------------------------------------------------------
   // Register read decode
   // ------------------------------------------------------------------
   function automatic logic [7:0] readReg(input logic [6:0] a,
                                          input cgcsr_top_state_t s);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         ADDR_P_DIV: r = s.pDiv;
         ADDR_M_DIV_HI: r = s.mHi;
         ADDR_M_DIV_LO: r = s.mLo;
         ADDR_N0_DIV: r = s.n0;
         ADDR_N1_DIV: r = s.n1;
         ADDR_OUTPUT_INPUT_CONTROL: r = s.oic;
         ADDR_HOLDOVER_MISC_CONTROL: r = s.hmc;
         ADDR_INPUT_MONITOR_STATUS: r = s.status;
         ADDR_RESERVED: r = s.rsvd;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Sub-blocks
   // ------------------------------------------------------------------
   // soft reset acts as reset pin
   assign coreRstn = resetn & ~masterResetPin & ~s_reg.swRst;

   cgcsr_spi_rx u_spi (
      .core_clk(core_clk),
      .resetn(coreRstn),
      .enable(spiModeSel),
      .csN(spiCsN),
      .scl(spiScl),
      .sda(spiSda),
      .wr(spiWr.src)
   );

   cgcsr_holdover #(
      .CTRL_W(CTRL_W)
   ) u_hold (
      .core_clk(core_clk),
      .resetn(coreRstn),
      .holdEn(s_reg.hmc[HMC_HOLD_EN]),
      .forceHold(s_reg.hmc[HMC_FORCE]),
      .acqNominal(s_reg.hmc[HMC_ACQ_NOM]),
      .acqSel(s_reg.hmc[HMC_ACQ_SEL]),
      .bothFailed(bothFailed),
      .pllCtrl(pllCtrl),
      .xtalCtrl(xtalCtrl),
      .inHoldover(inHold)
   );

   // ------------------------------------------------------------------
   // Input enables
   // ------------------------------------------------------------------
   // input enable field
   always_comb begin
      if (s_reg.oic[OIC_IN_EN_HI:OIC_IN_EN_LO] == IN_EN_BY_PINS) begin
         enA = inputSelectPinA;
         enB = inputSelectPinB;
      end else begin
         enA = s_reg.oic[OIC_IN_EN_LO];
         enB = s_reg.oic[OIC_IN_EN_HI];
      end
   end

   assign bothFailed = (!enA || refFailA) && (!enB || refFailB);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic sclRise;
      logic sclFall;
      logic startC;
      logic stopC;
      logic wrEn;
      logic [6:0] wa;
      logic [7:0] wd;
      logic [7:0] rb;
      logic defB;
      logic curFail;
      logic othOk;
      logic defOk;
      sclRise = i2cScl & ~s_reg.sclPrev;
      sclFall = ~i2cScl & s_reg.sclPrev;
      startC = i2cScl & s_reg.sclPrev & s_reg.sdaPrev & ~i2cSdaIn;
      stopC = i2cScl & s_reg.sclPrev & ~s_reg.sdaPrev & i2cSdaIn;
      wrEn = 1'b0;
      wa = 7'h00;
      wd = 8'h00;
      rb = 8'h00;
      defB = s_reg.oic[OIC_DEF_B];
      curFail = s_reg.useB ? (refFailB || !enB) : (refFailA || !enA);
      othOk = s_reg.useB ? (enA && !refFailA) : (enB && !refFailB);
      defOk = defB ? (enB && !refFailB) : (enA && !refFailA);
      s_next = s_reg;
      s_next.sclPrev = i2cScl;
      s_next.sdaPrev = i2cSdaIn;
      s_next.monRst = 1'b0;
      s_next.swRst = 1'b0;

      // Two-wire slave
      if (spiModeSel || stopC) begin
         s_next.st = ST_IDLE;
         s_next.sdaOen = 1'b1;
      end else if (startC) begin
         s_next.st = ST_ADDR;
         s_next.bitCnt = 4'h0;
         s_next.sdaOen = 1'b1;
      end else begin
         unique case (s_reg.st)
            ST_IDLE: begin
            end
            ST_ADDR, ST_CMD, ST_WDATA: begin
               if (sclRise && s_reg.bitCnt != BYTE_BITS) begin
                  s_next.shift = {s_reg.shift[6:0], i2cSdaIn};
                  s_next.bitCnt = s_reg.bitCnt + 4'h1;
               end else if (sclFall && s_reg.bitCnt == BYTE_BITS) begin
                  s_next.bitCnt = 4'h0;
                  s_next.sdaOen = 1'b0;
                  s_next.st = ST_ACK;
                  if (s_reg.st == ST_ADDR) begin
                     if (s_reg.shift[7:1] != DEV_ADDR) begin
                        s_next.st = ST_IDLE;
                        s_next.sdaOen = 1'b1;
                     end else if (s_reg.shift[0]) begin
                        s_next.afterAck = ST_RDATA;
                     end else begin
                        s_next.afterAck = ST_CMD;
                     end
                  end else if (s_reg.st == ST_CMD) begin
                     s_next.ptr = s_reg.shift[6:0];
                     s_next.afterAck = ST_WDATA;
                  end else begin
                     wrEn = 1'b1;
                     wa = s_reg.ptr;
                     wd = s_reg.shift;
                     s_next.ptr = s_reg.ptr + 7'h01;
                     s_next.afterAck = ST_WDATA;
                  end
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  s_next.st = s_reg.afterAck;
                  s_next.bitCnt = 4'h0;
                  s_next.sdaOen = 1'b1;
                  if (s_reg.afterAck == ST_RDATA) begin
                     rb = readReg(s_reg.ptr, s_reg);
                     s_next.sdaOen = rb[7];
                     s_next.shift = {rb[6:0], 1'b0};
                     s_next.bitCnt = 4'h1;
                  end
               end
            end
            ST_RDATA: begin
               if (sclFall) begin
                  if (s_reg.bitCnt == BYTE_BITS) begin
                     s_next.sdaOen = 1'b1;
                     s_next.st = ST_RACK;
                  end else begin
                     s_next.sdaOen = s_reg.shift[7];
                     s_next.shift = {s_reg.shift[6:0], 1'b0};
                     s_next.bitCnt = s_reg.bitCnt + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (sclRise) begin
                  if (i2cSdaIn) begin
                     s_next.st = ST_IDLE;
                  end else begin
                     s_next.ptr = s_reg.ptr + 7'h01;
                     s_next.afterAck = ST_RDATA;
                     s_next.st = ST_ACK;
                  end
               end
            end
            default: begin
               s_next.st = ST_IDLE;
               s_next.sdaOen = 1'b1;
            end
         endcase
      end

      // Three-wire writes when the two-wire port is idle
      if (!wrEn && spiWr.wrStb) begin
         wrEn = 1'b1;
         wa = spiWr.wrAddr;
         wd = spiWr.wrData;
      end

      // Register writes
      if (wrEn) begin
         unique case (wa)
            ADDR_P_DIV: s_next.pDiv = wd;
            ADDR_M_DIV_HI: s_next.mHi = wd;
            ADDR_M_DIV_LO: s_next.mLo = wd;
            ADDR_N0_DIV: s_next.n0 = wd;
            ADDR_N1_DIV: s_next.n1 = wd;
            ADDR_OUTPUT_INPUT_CONTROL: begin
               s_next.oic = wd & OIC_STORE_MASK;
               s_next.monRst = wd[OIC_MON_RST];
            end
            ADDR_HOLDOVER_MISC_CONTROL: begin
               s_next.hmc = wd & HMC_STORE_MASK;
               s_next.swRst = wd[HMC_SW_RST];
            end
            ADDR_RESERVED: s_next.rsvd = wd;
            default: begin
            end
         endcase
      end

      // Input monitor
      // active input choice
      s_next.failAPrev = refFailA;
      s_next.failBPrev = refFailB;
      if (s_reg.monRst && s_reg.oic[OIC_REVERT]) begin
         s_next.useB = defB;
         s_next.intFlag = 1'b0;
      end else if (curFail && othOk) begin
         s_next.useB = !s_reg.useB;
      end else if (s_reg.oic[OIC_REVERT] && s_reg.useB != defB && defOk) begin
         s_next.useB = defB;
      end
      // Failure event sets interrupt, wins over clear
      if ((enA && refFailA && !s_reg.failAPrev) ||
          (enB && refFailB && !s_reg.failBPrev)) begin
         s_next.intFlag = 1'b1;
      end

      s_next.status = {s_reg.intFlag, refFailA, refFailB, s_reg.useB,
                       pllUnlocked, inHold, 2'b00};

      // Clock outputs
      // output gating
      s_next.clock_output_second = divFirstClk & ~s_reg.oic[OIC_OUT_DIS];
      s_next.clk1Oen = ~s_reg.oic[OIC_EN_FIRST];
      s_next.clock_output_third = divSecondClk & ~s_reg.oic[OIC_OUT_DIS];
      s_next.clk2Oen = ~s_reg.oic[OIC_EN_SECOND];
      s_next.clk3 = (s_reg.hmc[HMC_DIV_ROUTE] ? divSecondClk : divFirstClk)
                    & ~s_reg.oic[OIC_OUT_DIS];
   end

   always_ff @(posedge core_clk) begin
      if (!coreRstn) begin
         s_reg <= TOP_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign i2cSdaOut = 1'b0;
   assign i2cSdaOen = s_reg.sdaOen;
   assign clockOutputFirst = s_reg.clock_output_second;
   assign clockOutputFirstOen = s_reg.clk1Oen;
   assign clockOutputSecond = s_reg.clock_output_third;
   assign clockOutputSecondOen = s_reg.clk2Oen;
   assign clockOutputThird = s_reg.clk3;
   assign refInputBActive = s_reg.useB;
   assign monitorIntr = s_reg.intFlag;
   assign pDivRatio = s_reg.pDiv;
   assign mDivRatio = {s_reg.mHi, s_reg.mLo};
   assign n0DivRatio = s_reg.n0;
   assign n1DivRatio = s_reg.n1;
endmodule

// file: sim/cgcsr_checker.sv
/* Port assertions for cgcsr_top.
   Bound to cgcsr_top; ports match its names. */
`timescale 1ns/1ps
module cgcsr_checker (
   input wire logic core_clk, // Clock
   input wire logic resetn, // Reset
   input wire logic masterResetPin, // Master reset
   input wire logic spiModeSel, // Three-wire mode
   input wire logic spiCsN, // Select
   input wire logic divFirstClk, // Divider A
   input wire logic divSecondClk, // Divider B
   input wire logic refFailA, // Fail A
   input wire logic refFailB, // Fail B
   input wire logic clockOutputFirst, // Out 1
   input wire logic clockOutputFirstOen, // Oen 1
   input wire logic clockOutputThird, // Out 3
   input wire logic monitorIntr, // Interrupt
   input wire logic [7:0] n0DivRatio // N0 code
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   chk_mreset_clear: assert property (masterResetPin |=>
      !clockOutputFirstOen && n0DivRatio == 8'h00) else $error("mr");
   chk_mreset_intr: assert property (masterResetPin [*2] |->
      !monitorIntr) else $error("mr intr");
   chk_reset_div: assert property ($rose(resetn) |->
      n0DivRatio == 8'h00 && !monitorIntr) else $error("rst");
   chk_out_gate: assert property (clockOutputFirst |->
      $past(divFirstClk)) else $error("out1");
   chk_third_src: assert property (clockOutputThird |->
      $past(divFirstClk) || $past(divSecondClk)) else $error("out3");
   chk_idle_stable: assert property (spiCsN [*5] ##0
      (spiModeSel && !masterResetPin) |=> $stable(n0DivRatio)
      && $stable(clockOutputFirstOen)) else $error("idle");
   chk_intr_hold: assert property (spiCsN [*5] ##0
      (monitorIntr && spiModeSel && !masterResetPin) |=> monitorIntr)
      else $error("ih");
   chk_intr_cause: assert property ($rose(monitorIntr) |->
      refFailA || refFailB) else $error("ic");
endmodule
bind cgcsr_top cgcsr_checker chk (.*);

// file: sim/cgcsr_spi_host.sv
/* Three-wire host model writing 16-bit words.
   Assumes core_clk from the bench; SCL low outside frames. */
`timescale 1ns/1ps
module cgcsr_spi_host (
   input wire logic core_clk, // Clock
   output logic spiCsN, // Select
   output logic spiScl, // Serial clock
   output logic spiSda // Serial data
);
   initial begin
      spiCsN = 1'b1;
      spiScl = 1'b0;
      spiSda = 1'b0;
   end
   task automatic send(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] w;
      w = {1'b0, a, d};
      @(negedge core_clk);
      spiCsN <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (4) @(negedge core_clk);
         spiSda <= w[i];
         repeat (4) @(negedge core_clk);
         spiScl <= 1'b1;
         repeat (4) @(negedge core_clk);
         spiScl <= 1'b0;
      end
      repeat (4) @(negedge core_clk);
      spiCsN <= 1'b1;
      spiSda <= ~spiSda;
      repeat (24) @(negedge core_clk);
   endtask
endmodule

// file: sim/tb.sv
/* Self-checking bench for cgcsr_top over both serial ports.
   Assumes cgcsr_spi_host as three-wire host; two-wire driven here. */
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0, resetn = 1'b0, mrPin = 1'b0, failA = 1'b0;
   logic divA = 1'b1, divB = 1'b0, csN, scl, sda, c1, c2, c3, o1, o2;
   logic bAct, intr, ackOen, spiMode = 1'b1, sclI = 1'b1, sdaI = 1'b1;
   logic [15:0] pll = 16'h0000, xtal, mDiv, v;
   logic [7:0] pDiv, n0, n1;
   logic [7:0] hw [2] = '{8'h22, 8'hC0};
   int fails = 0, checks = 0, seed = 46268;
   int regs [9];
   always #2.5 core_clk = ~core_clk;
   cgcsr_spi_host host (.core_clk(core_clk), .spiCsN(csN),
      .spiScl(scl), .spiSda(sda));
   cgcsr_top uut (.core_clk(core_clk), .resetn(resetn),
      .masterResetPin(mrPin), .spiModeSel(spiMode), .i2cScl(sclI),
      .i2cSdaIn(sdaI & ackOen), .i2cSdaOut(), .i2cSdaOen(ackOen),
      .spiCsN(csN),
      .spiScl(scl), .spiSda(sda), .inputSelectPinA(1'b1),
      .inputSelectPinB(1'b1), .refFailA(failA), .refFailB(1'b0),
      .pllUnlocked(1'b0), .divFirstClk(divA), .divSecondClk(divB),
      .pllCtrl(pll), .clockOutputFirst(c1), .clockOutputFirstOen(o1),
      .clockOutputSecond(c2), .clockOutputSecondOen(o2),
      .clockOutputThird(c3), .refInputBActive(bAct), .monitorIntr(intr),
      .xtalCtrl(xtal), .pDivRatio(pDiv), .mDivRatio(mDiv),
      .n0DivRatio(n0), .n1DivRatio(n1));
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(logic [6:0] a, logic [7:0] d);
      host.send(a, d);
      regs[a] = d;
   endtask
   // Two-wire byte, then the ack bit with SDA released
   task automatic i2c_byte(logic [7:0] b);
      for (int j = 8; j >= 0; j--) begin
         sdaI = j ? b[j-1] : 1'b1;
         repeat (4) @(negedge core_clk);
         sclI = 1'b1;
         repeat (4) @(negedge core_clk);
         if (j == 0)
            chk(ackOen, 1'b0);
         sclI = 1'b0;
      end
   endtask
   task automatic cmp();
      chk({o1, o2}, {~regs[5][6], ~regs[5][5]});
      chk({c1, c2, c3}, {divA, divB, regs[6][2] ? divB : divA}
         & {3{~regs[5][7]}});
      chk({pDiv, n0}, {regs[0][7:0], regs[3][7:0]});
      chk(mDiv, {regs[1][7:0], regs[2][7:0]});
      chk(n1, regs[4][7:0]);
   endtask
   task automatic complete_run();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      complete_run();
   end
   initial begin
      repeat (6) @(negedge core_clk);
      resetn = 1'b1;
      for (int r = 0; r < 3; r++) begin
         regs = '{0, 0, 0, 0, 0, 8'h60, 0, 0, 0};
         repeat (2) @(negedge core_clk);
         cmp();
         for (int i = 0; i < 10; i++) begin
            {divA, divB} = 2'($random(seed));
            wr(7'(i % 5), 8'($random(seed)));
            wr(7'h05, 8'($random(seed)));
            wr(7'h06, 8'($random(seed)) & 8'hE7);
            cmp();
         end
         if (r == 0)
            wr(7'h06, 8'h10);
         else begin
            mrPin = 1'b1;
            repeat (2) @(negedge core_clk);
            mrPin = 1'b0;
         end
      end
      foreach (hw[k]) begin
         pll = 16'($random(seed));
         v = pll;
         wr(7'h06, hw[k]);
         pll = 16'($random(seed));
         repeat (2) @(negedge core_clk);
         chk(xtal, v);
         wr(7'h06, 8'h00);
         chk(xtal, pll);
      end
      wr(7'h05, 8'h6E);
      failA = 1'b1;
      repeat (8) @(negedge core_clk);
      chk({intr, bAct}, 2'b11);
      failA = 1'b0;
      repeat (8) @(negedge core_clk);
      chk({intr, bAct}, 2'b10);
      wr(7'h05, 8'h6F);
      chk({intr, bAct}, 2'b00);
      // Two-wire write of two bytes from pointer 3
      v = 16'($random(seed));
      spiMode = 1'b0;
      repeat (4) @(negedge core_clk);
      sdaI = 1'b0;
      repeat (4) @(negedge core_clk);
      sclI = 1'b0;
      i2c_byte({cgcsr_pkg::I2C_DEV_ADDR, 1'b0});
      i2c_byte(8'h03);
      i2c_byte(v[15:8]);
      i2c_byte(v[7:0]);
      sdaI = 1'b0;
      repeat (4) @(negedge core_clk);
      sclI = 1'b1;
      repeat (4) @(negedge core_clk);
      sdaI = 1'b1;
      repeat (4) @(negedge core_clk);
      chk({n0, n1}, v);
      complete_run();
   end
endmodule
